// [logic/pmc24_defs.svh]
`ifndef PMC24_DEFS_SVH
`define PMC24_DEFS_SVH
// =============================================
// Register map
`define PMC24_REG_CTRL 12'h000
`define PMC24_REG_STATUS 12'h004
`define PMC24_REG_CUR_COUNT 12'h008
`define PMC24_REG_CUR_ELAPSED 12'h00c
`define PMC24_REG_REC_COUNT 12'h010
`define PMC24_REG_REC_ELAPSED 12'h014
`define PMC24_REG_BLOCKS 12'h018
`define PMC24_REG_RPT_COUNT 12'h01c
`define PMC24_REG_RPT_ELAPSED 12'h020
// =============================================
// Field positions
`define PMC24_CTRL_ENABLE 0
`define PMC24_CTRL_MODE_SES 1
`define PMC24_CTRL_REPORT 2
`define PMC24_CTRL_LOST 3
`define PMC24_ST_CUR_SUSPECT 0
`define PMC24_ST_REC_SUSPECT 1
`define PMC24_ST_RPT_SUSPECT 2
`define PMC24_ST_RPT_VALID 3
// =============================================
// Values and timing
`define PMC24_NOMINAL_S 17'd86400
`define PMC24_MARGIN_S 17'd10
`define PMC24_ELAPSED_MAX 17'h1ffff
`define PMC24_COUNT_MAX 32'hffffffff
`define PMC24_BLOCKS_RST 16'h1f40
`define PMC24_RESP_OKAY 2'h0
`define PMC24_RESP_SLVERR 2'h2
`endif

// [logic/pmc24_pkg.sv]
package pmc24_pkg;
  typedef struct packed {
    logic [31:0] count;
    logic [16:0] elapsed;
    logic suspect;
  } pmc24_reg_s;
  typedef enum logic [1:0] {
    PMC24_IDLE = 2'b00,
    PMC24_RUN = 2'b01,
    PMC24_XFER = 2'b11
  } pmc24_state_e;
endpackage

// [logic/pmc24_hold.sv]
`timescale 1ns/10ps
module pmc24_hold
  import pmc24_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input pmc24_reg_s wr_data,
  output pmc24_reg_s rd_data
);
  // =============================================
  // One-word store, read straight from the store register
  pmc24_reg_s mem_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mem_q <= '0;
    end
    else if (wr_en)
    begin
      mem_q <= wr_data;
    end
  end
  assign rd_data = mem_q;
endmodule

// [logic/pmc24_current.sv]
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps
`include "pmc24_defs.svh"
module pmc24_current
  import pmc24_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic monitoring_second_tick,
  input wire logic period_end,
  input wire logic clock_outside_interval,
  input wire logic clock_preset_large,
  input wire logic indication_valid,
  input wire logic [15:0] background_block_error,
  input wire logic severely_errored_second,
  input wire logic unavailable_time,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic period_done,
  output logic current_suspect
);
  typedef struct packed {
    pmc24_state_e st;
    pmc24_reg_s cur;
    pmc24_reg_s rpt;
    logic rpt_valid;
    logic enable;
    logic mode_ses;
    logic lost;
    logic [15:0] blocks;
    logic aw_got;
    logic w_got;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic done;
  } pmc24_state_s;

  pmc24_state_s s_q;
  pmc24_state_s s_d;
  pmc24_reg_s rec_rd;
  logic rec_wr;

  // =============================================
  // Helpers
  function automatic logic known_addr(input logic [11:0] a);
    case (a)
      `PMC24_REG_CTRL, `PMC24_REG_STATUS, `PMC24_REG_CUR_COUNT,
      `PMC24_REG_CUR_ELAPSED, `PMC24_REG_REC_COUNT,
      `PMC24_REG_REC_ELAPSED, `PMC24_REG_BLOCKS,
      `PMC24_REG_RPT_COUNT, `PMC24_REG_RPT_ELAPSED: known_addr = 1'b1;
      default: known_addr = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    wmerge = r;
  endfunction

  function automatic logic off_nominal(input logic [16:0] e);
    off_nominal = (e > `PMC24_NOMINAL_S + `PMC24_MARGIN_S) ||
                  (e < `PMC24_NOMINAL_S - `PMC24_MARGIN_S);
  endfunction

  function automatic logic close_req(input logic pe, input logic oi);
    close_req = pe || oi;
  endfunction

  // =============================================
  // Recent register store
  pmc24_hold u_recent (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(rec_wr),
    .wr_data(s_q.cur),
    .rd_data(rec_rd)
  );
  assign rec_wr = (s_q.st == PMC24_XFER);

  // =============================================
  // Next state
  always_comb
  begin
    logic [15:0] bbe_cap;
    logic [32:0] sum;
    logic [31:0] ctrl_old;
    logic [31:0] ctrl_new;
    logic processed;
    logic [31:0] inc;
    logic closing;
    logic snap;
    bbe_cap = 16'h0;
    sum = 33'h0;
    ctrl_old = 32'h0;
    ctrl_new = 32'h0;
    processed = 1'b0;
    inc = 32'h0;
    closing = close_req(period_end, clock_outside_interval);
    snap = 1'b0;
    s_d = s_q;
    s_d.done = 1'b0;

    // Counter engine
    case (s_q.st)
      PMC24_IDLE:
      begin
        s_d.cur = '0;
        if (s_q.enable)
        begin
          s_d.st = PMC24_RUN;
        end
      end
      PMC24_RUN:
      begin
        if (!s_q.enable)
        begin
          s_d.st = PMC24_IDLE;
        end
        else if (closing)
        begin
          s_d.st = PMC24_XFER;
        end
        else
        begin
          processed = monitoring_second_tick && indication_valid;
          if (s_q.blocks == 16'h0)
          begin
            bbe_cap = 16'h0;
          end
          else if (background_block_error > s_q.blocks - 16'h1)
          begin
            bbe_cap = s_q.blocks - 16'h1;
          end
          else
          begin
            bbe_cap = background_block_error;
          end
          if (s_q.mode_ses)
          begin
            inc = {31'h0, severely_errored_second &&
                   !unavailable_time};
          end
          else
          begin
            inc = {16'h0, bbe_cap};
          end
          if (processed)
          begin
            sum = {1'b0, s_q.cur.count} + {1'b0, inc};
            s_d.cur.count = sum[32] ? `PMC24_COUNT_MAX : sum[31:0];
            if (s_q.cur.elapsed != `PMC24_ELAPSED_MAX)
            begin
              s_d.cur.elapsed = s_q.cur.elapsed + 17'h1;
            end
          end
          if (clock_preset_large || s_q.lost)
          begin
            s_d.cur.suspect = 1'b1;
          end
        end
      end
      PMC24_XFER:
      begin
        s_d.cur = '0;
        s_d.done = 1'b1;
        s_d.st = PMC24_RUN;
      end
      default:
      begin
        s_d.st = PMC24_IDLE;
      end
    endcase

    // Loss request latches until applied to the running period
    if (s_q.lost && s_q.st == PMC24_RUN && s_q.enable)
    begin
      s_d.lost = 1'b0;
    end

    // Bus: write channel
    if (!s_q.aw_got && s_axi_awvalid)
    begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (!s_q.w_got && s_axi_wvalid)
    begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid)
    begin
      s_d.bvalid = 1'b1;
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bresp = known_addr(s_q.awaddr) ? `PMC24_RESP_OKAY
                                         : `PMC24_RESP_SLVERR;
      case (s_q.awaddr)
        `PMC24_REG_CTRL:
        begin
          ctrl_old = {28'h0, 1'b0, 1'b0, s_q.mode_ses, s_q.enable};
          ctrl_new = wmerge(ctrl_old, s_q.wdata, s_q.wstrb);
          s_d.enable = ctrl_new[`PMC24_CTRL_ENABLE];
          s_d.mode_ses = ctrl_new[`PMC24_CTRL_MODE_SES];
          if (ctrl_new[`PMC24_CTRL_REPORT])
          begin
            snap = 1'b1;
          end
          if (ctrl_new[`PMC24_CTRL_LOST])
          begin
            s_d.lost = 1'b1;
          end
        end
        `PMC24_REG_BLOCKS:
        begin
          ctrl_new = wmerge({16'h0, s_q.blocks}, s_q.wdata, s_q.wstrb);
          s_d.blocks = ctrl_new[15:0];
        end
        default:
        begin
          s_d.blocks = s_q.blocks;
        end
      endcase
    end
    if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid = 1'b0;
    end

    // Elapsed check applied at period close
    if (s_q.st == PMC24_RUN && closing)
    begin
      if (off_nominal(s_q.cur.elapsed) || s_q.lost)
      begin
        s_d.cur.suspect = 1'b1;
      end
    end

    // Report snapshot sees the settled current value
    if (snap)
    begin
      s_d.rpt = s_d.cur;
      s_d.rpt_valid = 1'b1;
    end

    // Bus: read channel
    if (s_axi_arvalid && !s_q.rvalid)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = known_addr(s_axi_araddr) ? `PMC24_RESP_OKAY
                                           : `PMC24_RESP_SLVERR;
      case (s_axi_araddr)
        `PMC24_REG_CTRL: s_d.rdata = {30'h0, s_q.mode_ses, s_q.enable};
        `PMC24_REG_STATUS: s_d.rdata = {28'h0, s_q.rpt_valid,
                                        s_q.rpt.suspect, rec_rd.suspect,
                                        s_q.cur.suspect};
        `PMC24_REG_CUR_COUNT: s_d.rdata = s_q.cur.count;
        `PMC24_REG_CUR_ELAPSED: s_d.rdata = {15'h0, s_q.cur.elapsed};
        `PMC24_REG_REC_COUNT: s_d.rdata = rec_rd.count;
        `PMC24_REG_REC_ELAPSED: s_d.rdata = {15'h0, rec_rd.elapsed};
        `PMC24_REG_BLOCKS: s_d.rdata = {16'h0, s_q.blocks};
        `PMC24_REG_RPT_COUNT: s_d.rdata = s_q.rpt.count;
        `PMC24_REG_RPT_ELAPSED: s_d.rdata = {15'h0, s_q.rpt.elapsed};
        default: s_d.rdata = 32'h0;
      endcase
    end
    if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid = 1'b0;
    end
  end

  // =============================================
  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q <= '0;
      s_q.st <= PMC24_IDLE;
      s_q.blocks <= `PMC24_BLOCKS_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // =============================================
  // Outputs
  assign s_axi_awready = !s_q.aw_got;
  assign s_axi_wready = !s_q.w_got;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign period_done = s_q.done;
  assign current_suspect = s_q.cur.suspect;
endmodule

// [dv/pmc24_current_props.sv]
`timescale 1ns/10ps
module pmc24_current_chk
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic period_end,
  input wire logic clock_outside_interval,
  input wire logic period_done,
  input wire logic current_suspect,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ==========
  // Checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_cause;
    period_done |-> $past(period_end, 2) || $past(clock_outside_interval, 2);
  endproperty
  a_cause: assert property (p_cause) else $error("late done");
  property p_init;
    period_done |-> !current_suspect;
  endproperty
  a_init: assert property (p_init) else $error("no init");
  property p_pulse;
    period_done |=> !period_done;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long done");
  property p_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("late b");
  property p_bdrop;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_bdrop: assert property (p_bdrop) else $error("b stuck");
  property p_rd;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd: assert property (p_rd) else $error("late r");
  property p_rdrop;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_rdrop: assert property (p_rdrop) else $error("r stuck");
  property p_rhold;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_rhold: assert property (p_rhold) else $error("ar open");
  c_done: cover property (period_done);
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind pmc24_current pmc24_current_chk u_chk (.*);

// [dv/pmc24_src.sv]
`timescale 1ns/10ps
module pmc24_src
(
  input wire logic aclk,
  input wire logic src_en,
  input wire logic [31:0] rnd,
  output logic monitoring_second_tick = 1'b0,
  output logic indication_valid = 1'b0,
  output logic [15:0] background_block_error = 16'h0000,
  output logic severely_errored_second = 1'b0,
  output logic unavailable_time = 1'b0
);
  // ==========
  // Second events at irregular spacing
  always @(posedge aclk)
  begin
    monitoring_second_tick <= src_en && rnd[1:0] != 2'h0;
    indication_valid <= rnd[4:3] != 2'h0;
    background_block_error <= {11'h000, rnd[20:16]};
    severely_errored_second <= rnd[8];
    unavailable_time <= rnd[9];
  end
endmodule

// [dv/test_pm_24h_current_register.sv]
`timescale 1ns/10ps
`include "pmc24_defs.svh"
module test_pm_24h_current_register;
  `define CHK(a, e) cmp_count++; if ((a) !== (e)) begin bad_count++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, e); end
  logic aclk = 1'b0, aresetn = 1'b0, src_en = 1'b0, ses_mode = 1'b0;
  logic period_end = 1'b0, clock_outside_interval = 1'b0;
  logic clock_preset_large = 1'b0, s_axi_bready = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, rnd = 32'h8f824e96, exp_cnt = 32'h0;
  logic [31:0] exp_el = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, period_done, current_suspect;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic monitoring_second_tick, indication_valid, severely_errored_second;
  logic unavailable_time;
  logic [15:0] background_block_error;
  int bad_count = 0;
  int cmp_count = 0;
  pmc24_src u_src (.*);
  pmc24_current dut (.*);
  // ==========
  // Expectation
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] gain(input logic [15:0] b, input logic s);
    if (ses_mode)
      return {31'h0, s};
    return (b > 16'd9) ? 32'd9 : {16'h0, b};
  endfunction
  initial
  begin
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk)
  begin
    rnd <= lfsr(rnd);
    if (monitoring_second_tick && indication_valid)
    begin
      exp_el <= exp_el + 32'd1;
      exp_cnt <= exp_cnt + gain(background_block_error,
        severely_errored_second && !unavailable_time);
    end
  end
  // ==========
  // Bus and period tasks
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, (a > 12'h020) ? 2'h2 : 2'h0)
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
    input logic [31:0] m);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata & m, e)
    `CHK(s_axi_rresp, (a > 12'h020) ? 2'h2 : 2'h0)
    @(posedge aclk);
  endtask
  task automatic fin(input logic oi);
    int n;
    n = 0;
    period_end <= !oi;
    clock_outside_interval <= oi;
    @(posedge aclk);
    period_end <= 1'b0;
    clock_outside_interval <= 1'b0;
    while (!period_done && n < 20)
    begin
      @(posedge aclk);
      n++;
    end
    `CHK(period_done, 1'b1)
  endtask
  task automatic final_report;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ==========
  // Scenarios
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`PMC24_REG_CUR_COUNT, 32'h0, '1);
    rd(`PMC24_REG_CUR_ELAPSED, 32'h0, '1);
    rd(`PMC24_REG_STATUS, 32'h0, 32'h1);
    rd(`PMC24_REG_BLOCKS, 32'h1f40, '1);
    rd(12'h100, 32'h0, '1);
    wr(12'h100, 32'h0);
    wr(`PMC24_REG_BLOCKS, 32'd10);
    for (int m = 0; m < 2; m++)
    begin
      ses_mode = m[0];
      exp_cnt = 32'h0;
      exp_el = 32'h0;
      wr(`PMC24_REG_CTRL, {30'h0, m[0], 1'b1});
      src_en <= 1'b1;
      repeat (300) @(posedge aclk);
      src_en <= 1'b0;
      repeat (3) @(posedge aclk);
      rd(`PMC24_REG_CUR_COUNT, exp_cnt, '1);
      rd(`PMC24_REG_CUR_ELAPSED, exp_el, '1);
      wr(`PMC24_REG_CTRL, {29'h0, 1'b1, m[0], 1'b1});
      rd(`PMC24_REG_RPT_COUNT, exp_cnt, '1);
      fin(m[0]);
      rd(`PMC24_REG_REC_COUNT, exp_cnt, '1);
      rd(`PMC24_REG_REC_ELAPSED, exp_el, '1);
      rd(`PMC24_REG_STATUS, 32'h2, 32'h3);
      rd(`PMC24_REG_CUR_ELAPSED, 32'h0, '1);
      if (m[0])
        wr(`PMC24_REG_CTRL, 32'hb);
      else
        clock_preset_large <= 1'b1;
      @(posedge aclk);
      clock_preset_large <= 1'b0;
      repeat (2) @(posedge aclk);
      `CHK(current_suspect, 1'b1)
    end
    wr(`PMC24_REG_CTRL, 32'h0);
    rd(`PMC24_REG_STATUS, 32'h0, 32'h1);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`PMC24_REG_BLOCKS, 32'h1f40, '1);
    final_report;
  end
  initial
  begin
    repeat (5000) @(posedge aclk);
    bad_count++;
    final_report;
  end
endmodule
